//--- src/nsend_pkg.sv
// Purpose: Shared constants and types for the network send control decoder
// Assumes: 125 MHz scan clock, 16-bit controller words
// Notes:   Field positions refer to the second control word unless named otherwise
package nsend_pkg;
   // ==========================================================================
   // Widths
   localparam int WORD_W = 16;
   localparam int CNT_W = 16;
   localparam int TICK_W = 24;

   // ==========================================================================
   // Control word fields
   localparam int FMT_BIT = 15;
   localparam int LEVEL_BIT = 14;
   localparam int NORESP_BIT = 13;
   localparam int LINK_ZERO_BIT = 12;
   localparam int RETRY_LO = 8;
   localparam logic [15:0] WIDE_ZERO_MASK = 16'hBF00;
   localparam logic [15:0] WIDE_MAX_CNT = 16'h03E8;
   localparam logic [15:0] LINK_MAX_CNT = 16'h0100;
   localparam logic [7:0] WIDE_MAX_NET = 8'h7F;
   localparam logic [7:0] WIDE_MAX_NODE = 8'h7E;
   localparam logic [7:0] LINK_MAX_NODE = 8'h3E;

   // ==========================================================================
   // Response time limit
   localparam int TICK_MS = 100;
   localparam int CLK_KHZ = 125000;
   localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
   localparam logic [7:0] LIMIT_DEFAULT_CODE = 8'h00;
   localparam logic [7:0] LIMIT_DEFAULT_TICKS = 8'h14;
   localparam logic [7:0] LIMIT_NONE = 8'hFF;

   // ==========================================================================
   // Types
   typedef enum logic [2:0] {
      NSEND_IDLE = 3'h0,
      NSEND_CHECK = 3'h1,
      NSEND_FETCH = 3'h2,
      NSEND_RESP = 3'h3,
      NSEND_FINISH = 3'h4
   } nsend_state_e;

   typedef struct packed {
      logic [15:0] w2;
      logic [15:0] w1;
      logic [15:0] w0;
   } nsend_ctl_s;

   typedef struct packed {
      logic link_fmt;
      logic level0;
      logic no_resp;
      logic [7:0] net_or_limit;
      logic [3:0] retries;
      logic [7:0] dest_node;
      logic [15:0] dest_addr;
      logic [15:0] count;
   } nsend_req_s;
endpackage

//--- src/nsend_buf2.sv
// Purpose: Two-entry buffer with registered outputs
// Assumes: Single clock, synchronous active-high reset
// Notes:   Head register feeds the output, tail holds a word during a stall
module nsend_buf2 #(
   parameter int W = 16
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   logic tail_valid;
   logic [W-1:0] tail;
   logic push;
   logic head_free;

   assign in_ready_o = !tail_valid;
   assign push = in_valid_i && !tail_valid;
   assign head_free = !out_valid_o || out_ready_i;

   // ==========================================================================
   // Storage
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         out_valid_o <= 1'b0;
         tail_valid <= 1'b0;
         out_data_o <= '0;
         tail <= '0;
      end else if (head_free) begin
         if (tail_valid) begin
            out_data_o <= tail;
            out_valid_o <= 1'b1;
            tail_valid <= push;
            if (push) begin
               tail <= in_data_i;
            end
         end else begin
            out_valid_o <= push;
            if (push) begin
               out_data_o <= in_data_i;
            end
         end
      end else if (push) begin
         tail <= in_data_i;
         tail_valid <= 1'b1;
      end
   end
endmodule // nsend_buf2

//--- src/nsend_ctl_top.sv
// Purpose: Decode, check and run a network send from a three-word control block
// Assumes: Program side and interface unit run on ref_clk_i; unit_present_i is a pin
// Notes:   Source words are read one at a time through a two-entry buffer
// Summary of operation
// (R1) Execution condition off: nothing; on: send source block to remote destination.
// (R2) Bit 15 of second word picks wide-address or link network layout.
// (R3) Wide network word count 0 to 1000 (0000 to 03E8).
// (R4) Link network word count 0 to 256 (0000 to 0100).
// (R5) Wide: second word low byte is network number 0 to 127, 0 local.
// (R6) Bit 14 picks operating level 0; wide format bits 8-13 and 15 zero.
// (R7) Wide: destination node 0 to 126, 0 broadcasts, own node allowed.
// (R8) Wide: destination port always zero.
// (R9) Link: low byte is response limit in 0.1 s; 00 is 2 s, FF none.
// (R10) Link: bits 8-11 retry count; bit 12 zero, bit 15 one.
// (R11) Link: bit 13 set means no response returned.
// (R12) Link: destination 0 to 62, high byte zero, own node forbidden.
// (R13) Error when destination node exceeds 126 wide or 62 link.
// (R14) Error when the block runs past its data area boundary.
// (R15) Error on faulty indirectly addressed operand word.
// (R16) Error and no transfer when no interface unit is mounted.
// (R17) Program keeps all three control words in one area, in range.
// (R18) Transfer completes only once the response is received and acknowledged, unless no response is returned (R11); code also ends it on R9 timeout.
// (R19) Enable flag low during transfer, high at first scan end after.
// (R20) Error flag cleared after normal completion.
// (R21) Control words captured at start; later changes have no effect.
module nsend_ctl_top #(
   parameter int unsigned TICK_CYCLES = nsend_pkg::TICK_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic exec_i,
   input wire logic scan_end_i,
   input wire nsend_pkg::nsend_ctl_s ctl_i,
   input wire logic [15:0] src_addr_i,
   input wire logic [15:0] dst_addr_i,
   input wire logic [15:0] src_area_last_i,
   input wire logic operand_fault_i,
   input wire logic [7:0] own_node_i,
   input wire logic unit_present_i,
   output logic mem_rd_o,
   output logic [15:0] mem_addr_o,
   input wire logic [15:0] mem_data_i,
   output logic net_start_o,
   output nsend_pkg::nsend_req_s net_req_o,
   output logic net_valid_o,
   input wire logic net_ready_i,
   output logic [15:0] net_data_o,
   input wire logic net_resp_i,
   output logic net_ack_o,
   output logic xfer_enable_o,
   output logic error_flag_o
);
   nsend_pkg::nsend_state_e state;
   nsend_pkg::nsend_ctl_s ctl;
   logic [15:0] src_addr;
   logic [15:0] dst_addr;
   logic [15:0] area_last;
   logic op_fault;
   logic unit_meta;
   logic unit_sync;
   logic link_fmt;
   logic no_resp_wait;
   logic err_node;
   logic err_fields;
   logic err_bound;
   logic err_op;
   logic any_err;
   logic [16:0] blk_end;
   logic [15:0] issued;
   logic rd_pending;
   logic buf_in_ready;
   logic stream_done;
   logic start;
   logic [nsend_pkg::TICK_W-1:0] tick_cnt;
   logic [7:0] ticks;
   logic [7:0] limit_ticks;
   logic limit_on;
   logic timeout;
   logic complete;

   // ==========================================================================
   // Unit presence synchroniser
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         unit_meta <= 1'b0;
         unit_sync <= 1'b0;
      end else begin
         unit_meta <= unit_present_i;
         unit_sync <= unit_meta;
      end
   end

   // ==========================================================================
   // Capture of control block and operands
   assign start = (state == nsend_pkg::NSEND_IDLE) && exec_i && xfer_enable_o; // R1 R19

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ctl <= '0;
         src_addr <= 16'h0000;
         dst_addr <= 16'h0000;
         area_last <= 16'h0000;
         op_fault <= 1'b0;
      end else if (start) begin
         ctl <= ctl_i; // R21
         src_addr <= src_addr_i;
         dst_addr <= dst_addr_i;
         area_last <= src_area_last_i;
         op_fault <= operand_fault_i;
      end
   end

   // ==========================================================================
   // Control block checks
   assign link_fmt = ctl.w1[nsend_pkg::FMT_BIT]; // R2
   assign no_resp_wait = link_fmt && ctl.w1[nsend_pkg::NORESP_BIT]; // R11
   assign blk_end = {1'b0, src_addr} + {1'b0, ctl.w0} - 17'h00001;

   always_comb begin
      if (link_fmt) begin
         err_node = (ctl.w2[7:0] > nsend_pkg::LINK_MAX_NODE); // R13
         err_fields = (ctl.w0 > nsend_pkg::LINK_MAX_CNT) // R4
            || ctl.w1[nsend_pkg::LINK_ZERO_BIT] // R10
            || (ctl.w2[15:8] != 8'h00) // R12
            || (ctl.w2[7:0] == own_node_i); // R12
      end else begin
         err_node = (ctl.w2[7:0] > nsend_pkg::WIDE_MAX_NODE); // R7 R13
         err_fields = (ctl.w0 > nsend_pkg::WIDE_MAX_CNT) // R3
            || ((ctl.w1 & nsend_pkg::WIDE_ZERO_MASK) != 16'h0000) // R6
            || (ctl.w1[7:0] > nsend_pkg::WIDE_MAX_NET) // R5
            || (ctl.w2[15:8] != 8'h00); // R8
      end
   end

   assign err_bound = (src_addr > area_last)
      || ((ctl.w0 != 16'h0000) && (blk_end > {1'b0, area_last})); // R14
   assign err_op = op_fault; // R15
   assign any_err = err_node || err_fields || err_bound || err_op || !unit_sync; // R16

   // ==========================================================================
   // Sequencer
   assign stream_done = (issued == ctl.w0) && !mem_rd_o && !rd_pending && !net_valid_o
      && buf_in_ready;
   assign complete = ((state == nsend_pkg::NSEND_RESP) && net_resp_i)
      || ((state == nsend_pkg::NSEND_FETCH) && stream_done && no_resp_wait); // R18

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state <= nsend_pkg::NSEND_IDLE;
      end else begin
         unique case (state)
            nsend_pkg::NSEND_IDLE: begin
               if (start) begin
                  state <= nsend_pkg::NSEND_CHECK;
               end
            end
            nsend_pkg::NSEND_CHECK: begin
               state <= any_err ? nsend_pkg::NSEND_FINISH : nsend_pkg::NSEND_FETCH;
            end
            nsend_pkg::NSEND_FETCH: begin
               if (stream_done) begin
                  state <= no_resp_wait ? nsend_pkg::NSEND_FINISH : nsend_pkg::NSEND_RESP;
               end
            end
            nsend_pkg::NSEND_RESP: begin
               if (net_resp_i || timeout) begin
                  state <= nsend_pkg::NSEND_FINISH; // R18
               end
            end
            nsend_pkg::NSEND_FINISH: begin
               if (scan_end_i) begin
                  state <= nsend_pkg::NSEND_IDLE;
               end
            end
            default: begin
               state <= nsend_pkg::NSEND_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // Request to the interface unit
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         net_start_o <= 1'b0;
         net_req_o <= '0;
      end else begin
         net_start_o <= (state == nsend_pkg::NSEND_CHECK) && !any_err; // R16
         if ((state == nsend_pkg::NSEND_CHECK) && !any_err) begin
            net_req_o.link_fmt <= link_fmt; // R2
            net_req_o.level0 <= ctl.w1[nsend_pkg::LEVEL_BIT]; // R6
            net_req_o.no_resp <= no_resp_wait; // R11
            net_req_o.net_or_limit <= ctl.w1[7:0]; // R5 R9
            net_req_o.retries <= link_fmt ? ctl.w1[nsend_pkg::RETRY_LO +: 4] : 4'h0; // R10
            net_req_o.dest_node <= ctl.w2[7:0]; // R7 R12
            net_req_o.dest_addr <= dst_addr; // R1
            net_req_o.count <= ctl.w0;
         end
      end
   end

   // ==========================================================================
   // Source word fetch
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         mem_rd_o <= 1'b0;
         mem_addr_o <= 16'h0000;
         issued <= 16'h0000;
         rd_pending <= 1'b0;
      end else begin
         mem_rd_o <= 1'b0;
         rd_pending <= mem_rd_o;
         if (state == nsend_pkg::NSEND_CHECK) begin
            issued <= 16'h0000;
            mem_addr_o <= src_addr;
         end else if ((state == nsend_pkg::NSEND_FETCH) && (issued != ctl.w0)
               && !mem_rd_o && !rd_pending && buf_in_ready) begin
            mem_rd_o <= 1'b1; // R1
            issued <= issued + 16'h0001;
         end else if (rd_pending) begin
            mem_addr_o <= mem_addr_o + 16'h0001;
         end
      end
   end

   nsend_buf2 #(
      .W(nsend_pkg::WORD_W)
   ) u_buf (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .in_valid_i(rd_pending),
      .in_ready_o(buf_in_ready),
      .in_data_i(mem_data_i),
      .out_valid_o(net_valid_o),
      .out_ready_i(net_ready_i),
      .out_data_o(net_data_o)
   );

   // ==========================================================================
   // Response time limit
   assign limit_ticks = (ctl.w1[7:0] == nsend_pkg::LIMIT_DEFAULT_CODE)
      ? nsend_pkg::LIMIT_DEFAULT_TICKS : ctl.w1[7:0]; // R9
   assign limit_on = link_fmt && (ctl.w1[7:0] != nsend_pkg::LIMIT_NONE); // R9
   assign timeout = limit_on && (ticks == limit_ticks);

   always_ff @(posedge ref_clk_i) begin
      if (reset_i || (state != nsend_pkg::NSEND_RESP)) begin
         tick_cnt <= '0;
         ticks <= 8'h00;
      end else if (tick_cnt == nsend_pkg::TICK_W'(TICK_CYCLES - 1)) begin
         tick_cnt <= '0;
         ticks <= ticks + 8'h01;
      end else begin
         tick_cnt <= tick_cnt + nsend_pkg::TICK_W'(1);
      end
   end

   // ==========================================================================
   // Flags
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         net_ack_o <= 1'b0;
      end else begin
         net_ack_o <= (state == nsend_pkg::NSEND_RESP) && net_resp_i; // R18
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         error_flag_o <= 1'b0;
      end else if ((state == nsend_pkg::NSEND_CHECK) && any_err) begin
         error_flag_o <= 1'b1; // R13 R14 R15 R16
      end else if ((state == nsend_pkg::NSEND_RESP) && timeout && !net_resp_i) begin
         error_flag_o <= 1'b1;
      end else if (complete) begin
         error_flag_o <= 1'b0; // R20
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         xfer_enable_o <= 1'b1;
      end else if (start) begin
         xfer_enable_o <= 1'b0; // R19
      end else if ((state == nsend_pkg::NSEND_FINISH) && scan_end_i) begin
         xfer_enable_o <= 1'b1; // R19
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   chk_idle_no_start: assert property ( // R1
      (state == nsend_pkg::NSEND_IDLE) && !exec_i |=> state == nsend_pkg::NSEND_IDLE)
      else $error("transfer started without execution condition");
   chk_format_select: assert property ( // R2
      net_start_o |-> net_req_o.link_fmt == ctl.w1[15])
      else $error("network format does not follow bit 15");
   chk_level_retry: assert property ( // R10
      net_start_o && net_req_o.link_fmt |-> net_req_o.retries == ctl.w1[11:8]
         && net_req_o.level0 == ctl.w1[14])
      else $error("retry count or level mismatch");
   chk_node_range: assert property ( // R13
      (state == nsend_pkg::NSEND_CHECK) && err_node |=> error_flag_o && !net_start_o)
      else $error("oversized destination node accepted");
   chk_block_bound: assert property ( // R14
      (state == nsend_pkg::NSEND_CHECK) && err_bound |=> error_flag_o
         && state == nsend_pkg::NSEND_FINISH)
      else $error("block overrun accepted");
   chk_operand_fault: assert property ( // R15
      (state == nsend_pkg::NSEND_CHECK) && op_fault |=> error_flag_o && !net_start_o)
      else $error("faulty operand accepted");
   chk_unit_absent: assert property ( // R16
      (state == nsend_pkg::NSEND_CHECK) && !unit_sync |=> !net_start_o ##1 !mem_rd_o)
      else $error("transfer without interface unit");
   chk_resp_ack: assert property ( // R18
      (state == nsend_pkg::NSEND_RESP) && net_resp_i |=> net_ack_o && !error_flag_o)
      else $error("response not acknowledged or error kept");
   chk_enable_low: assert property ( // R19
      (state != nsend_pkg::NSEND_IDLE) && !$past(state == nsend_pkg::NSEND_IDLE)
         |-> !xfer_enable_o)
      else $error("enable high during transfer");
   chk_enable_rise: assert property ( // R19
      (state == nsend_pkg::NSEND_FINISH) && scan_end_i |=> xfer_enable_o
         && state == nsend_pkg::NSEND_IDLE)
      else $error("enable not raised at scan end");
   chk_capture_hold: assert property ( // R21
      (state != nsend_pkg::NSEND_IDLE) && (state != nsend_pkg::NSEND_CHECK) |-> $stable(ctl))
      else $error("control block changed during transfer");
endmodule // nsend_ctl_top

//--- tb/nsend_unit_model.sv
// Purpose: Behavioural network interface unit facing the send decoder
// Assumes: Drives just after the rising edge; answers only while answer_i is high
// Notes:   Ready stalls at random while stall_i is high
module nsend_unit_model (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic net_start_i,
   input wire nsend_pkg::nsend_req_s net_req_i,
   input wire logic net_valid_i,
   input wire logic stall_i,
   input wire logic answer_i,
   output logic net_ready_o,
   output logic net_resp_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 32'h6710;
   int left;
   int delay;
   logic pend;
   // ==========================================================================
   // Word acceptance and response
   always @(posedge ref_clk_i) begin
      net_resp_o <= 1'b0;
      net_ready_o <= stall_i ? (($random(seed) & 3) == 0) : 1'b1;
      if (reset_i) begin
         left = 0;
         pend = 1'b0;
         net_ready_o <= 1'b0;
      end else if (net_start_i) begin
         left = int'(net_req_i.count);
         pend = !(net_req_i.link_fmt && net_req_i.no_resp);
         delay = 3 + ($random(seed) & 7);
      end else if (net_valid_i && net_ready_o && left > 0) begin
         left--;
      end else if (pend && left == 0 && answer_i) begin
         // Answer only after the whole block has been taken
         if (delay == 0) begin
            net_resp_o <= 1'b1;
            pend = 1'b0;
         end else begin
            delay--;
         end
      end
   end
endmodule // nsend_unit_model

//--- tb/nsend_ctl_top_tb.sv
// Purpose: Self-checking bench for the network send control decoder
// Assumes: Inputs driven at the falling edge; tick shortened to 10 cycles
// Notes:   Source memory answers one cycle after each read strobe
module nsend_ctl_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK_EQ(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
   int seed = 32'h6710;
   int checked = 0;
   int error_cnt = 0;
   int words, acks, starts;
   logic clk, rst, exec, scan_end, fault, present, stall, answer;
   logic mem_rd, net_start, net_valid, net_ready, net_resp, net_ack, xfer_enable, error_flag;
   logic rd_q, en_q, se_q, se_qq;
   logic [7:0] own;
   logic [15:0] src_addr, dst_addr, last, mem_addr, mem_data, net_data, a_q, exp_src;
   nsend_pkg::nsend_ctl_s ctl;
   nsend_pkg::nsend_req_s net_req, req_seen;

   nsend_ctl_top #(.TICK_CYCLES(10)) u_dut (
      .ref_clk_i(clk), .reset_i(rst), .exec_i(exec), .scan_end_i(scan_end), .ctl_i(ctl),
      .src_addr_i(src_addr), .dst_addr_i(dst_addr), .src_area_last_i(last),
      .operand_fault_i(fault), .own_node_i(own), .unit_present_i(present),
      .mem_rd_o(mem_rd), .mem_addr_o(mem_addr), .mem_data_i(mem_data),
      .net_start_o(net_start), .net_req_o(net_req), .net_valid_o(net_valid),
      .net_ready_i(net_ready), .net_data_o(net_data), .net_resp_i(net_resp),
      .net_ack_o(net_ack), .xfer_enable_o(xfer_enable), .error_flag_o(error_flag));

   nsend_unit_model u_unit (
      .ref_clk_i(clk), .reset_i(rst), .net_start_i(net_start), .net_req_i(net_req),
      .net_valid_i(net_valid), .stall_i(stall), .answer_i(answer),
      .net_ready_o(net_ready), .net_resp_o(net_resp));

   function automatic logic [15:0] word_at(input logic [15:0] a);
      return {a[7:0], a[15:8]} ^ 16'h5A3C;
   endfunction

   function automatic nsend_pkg::nsend_ctl_s mk(input logic lk, input logic [15:0] cnt,
                                                input logic [7:0] nd, input logic [7:0] lo);
      nsend_pkg::nsend_ctl_s c;
      logic [15:0] r;
      r = 16'($random(seed));
      c.w0 = cnt;
      c.w1 = lk ? {1'b1, r[14:13], 1'b0, r[11:8], lo} : {1'b0, r[14], 6'h00, lo};
      c.w2 = {8'h00, nd};
      return c;
   endfunction

   function automatic nsend_pkg::nsend_req_s exp_req(input nsend_pkg::nsend_ctl_s c,
                                                     input logic [15:0] d);
      nsend_pkg::nsend_req_s r;
      r.link_fmt = c.w1[nsend_pkg::FMT_BIT];
      r.level0 = c.w1[nsend_pkg::LEVEL_BIT];
      r.no_resp = r.link_fmt & c.w1[nsend_pkg::NORESP_BIT];
      r.net_or_limit = c.w1[7:0];
      r.retries = r.link_fmt ? c.w1[11:8] : 4'h0;
      r.dest_node = c.w2[7:0];
      r.dest_addr = d;
      r.count = c.w0;
      return r;
   endfunction

   task automatic results;
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic send(input nsend_pkg::nsend_ctl_s c, input logic [15:0] src,
                       input logic e_err, input logic e_start);
      logic [15:0] d;
      int n;
      d = 16'($random(seed));
      @(negedge clk);
      ctl = c;
      src_addr = src;
      dst_addr = d;
      exec = 1'b1;
      exp_src = src;
      words = 0;
      acks = 0;
      starts = 0;
      @(negedge clk);
      exec = 1'b0;
      // Scramble the operands once captured
      ctl = 48'({$random(seed), $random(seed)});
      src_addr = 16'($random(seed));
      dst_addr = 16'($random(seed));
      @(negedge clk);
      `CHK_EQ(xfer_enable, 1'b0)
      n = 0;
      while (xfer_enable !== 1'b1 && n < 6000) begin
         @(negedge clk);
         n++;
      end
      `CHK_EQ(xfer_enable, 1'b1)
      `CHK_EQ(error_flag, e_err)
      `CHK_EQ(starts, int'(e_start))
      if (e_start) begin
         `CHK_EQ(req_seen, exp_req(c, d))
         `CHK_EQ(words, int'(c.w0))
         `CHK_EQ(acks, int'(!e_err && !(c.w1[15] && c.w1[13])))
      end
   endtask

   // ==========================================================================
   // Clock, scan ends and source memory
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial scan_end = 1'b0;
   always @(negedge clk) scan_end <= !scan_end && (({$random(seed)} % 6) == 0);

   always @(posedge clk) begin
      rd_q <= mem_rd;
      a_q <= mem_addr;
   end
   // Outside the answer cycle the data lines show a wrong word
   assign mem_data = rd_q ? word_at(a_q) : ~word_at(a_q);

   // ==========================================================================
   // Output monitor
   always @(posedge clk) begin
      if (!rst && xfer_enable === 1'b1 && en_q === 1'b0) begin
         `CHK_EQ(se_q | se_qq, 1'b1)
      end
      en_q = xfer_enable;
      se_qq = se_q;
      se_q = scan_end;
      if (net_start === 1'b1) begin
         starts++;
         req_seen = net_req;
      end
      if (net_valid === 1'b1 && net_ready === 1'b1) begin
         `CHK_EQ(net_data, word_at(exp_src + 16'(words)))
         words++;
      end
      if (net_ack === 1'b1) acks++;
   end

   initial begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      results();
   end

   // ==========================================================================
   // Main sequence
   initial begin
      nsend_pkg::nsend_ctl_s c;
      logic lk;
      logic [7:0] nd, lo;
      rst = 1'b1;
      exec = 1'b0;
      ctl = '0;
      src_addr = '0;
      dst_addr = '0;
      last = 16'hFFFF;
      fault = 1'b0;
      own = 8'h21;
      present = 1'b1;
      stall = 1'b0;
      answer = 1'b1;
      en_q = 1'b1;
      se_q = 1'b0;
      se_qq = 1'b0;
      starts = 0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      `CHK_EQ(xfer_enable, 1'b1)
      `CHK_EQ(error_flag, 1'b0)
      repeat (40) @(negedge clk);
      `CHK_EQ(starts, 0)
      send(mk(1'b0, 16'h03E8, 8'h7E, 8'h7F), 16'h1000, 1'b0, 1'b1);
      send(mk(1'b1, 16'h0100, 8'h3E, 8'hFF), 16'h2000, 1'b0, 1'b1);
      send(mk(1'b0, 16'h0000, 8'h00, 8'h00), 16'h3000, 1'b0, 1'b1);
      c = mk(1'b1, 16'h0005, 8'h03, 8'h00);
      c.w1[13] = 1'b1;
      send(c, 16'h3100, 1'b0, 1'b1);
      answer = 1'b0;
      fork
         send(mk(1'b0, 16'h0003, 8'h02, 8'h00), 16'h0500, 1'b0, 1'b1);
         begin
            repeat (400) @(negedge clk);
            `CHK_EQ(xfer_enable, 1'b0)
            `CHK_EQ(error_flag, 1'b0)
            // Start request while busy must be ignored
            exec = 1'b1;
            @(negedge clk);
            exec = 1'b0;
            answer = 1'b1;
         end
      join
      answer = 1'b0;
      c = mk(1'b1, 16'h0002, 8'h04, 8'h03);
      c.w1[13] = 1'b0;
      send(c, 16'h0600, 1'b1, 1'b1);
      answer = 1'b1;
      for (int i = 0; i < 10; i++) begin
         c = mk(i[0], 16'h0004, 8'h05, 8'h00);
         case (i)
            0: c.w2[7:0] = 8'h7F;
            1: c.w2[7:0] = 8'h3F;
            2: c.w0 = 16'h03E9;
            3: c.w0 = 16'h0101;
            4: c.w1[8] = 1'b1;
            5: c.w1[12] = 1'b1;
            6: c.w2[15:8] = 8'h01;
            7: c.w2[7:0] = own;
            8: c.w1[7:0] = 8'h80;
            default: c.w2[15:8] = 8'h01;
         endcase
         send(c, 16'h0400, 1'b1, 1'b0);
      end
      last = 16'h0106;
      send(mk(1'b0, 16'h0008, 8'h01, 8'h00), 16'h0100, 1'b1, 1'b0);
      last = 16'h0107;
      send(mk(1'b0, 16'h0008, 8'h01, 8'h00), 16'h0100, 1'b0, 1'b1);
      last = 16'hFFFF;
      fault = 1'b1;
      send(mk(1'b1, 16'h0002, 8'h01, 8'hFF), 16'h0200, 1'b1, 1'b0);
      fault = 1'b0;
      present = 1'b0;
      repeat (4) @(negedge clk);
      send(mk(1'b0, 16'h0002, 8'h01, 8'h00), 16'h0200, 1'b1, 1'b0);
      present = 1'b1;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 30; i++) begin
         lk = 1'($random(seed));
         stall = 1'($random(seed));
         nd = lk ? 8'({$random(seed)} % 63) : 8'({$random(seed)} % 127);
         if (lk && nd == own) nd = 8'h00;
         lo = lk ? 8'h20 + 8'({$random(seed)} % 64) : 8'({$random(seed)} % 128);
         send(mk(lk, 16'({$random(seed)} % 21), nd, lo), 16'({$random(seed)} % 28672),
              1'b0, 1'b1);
      end
      results();
   end
endmodule // nsend_ctl_top_tb
